// >>> fault_cfg_pkg.sv
package fault_cfg_pkg;

  // Register indices; byte address is four times the index
  localparam int unsigned IDX_FAULT_RESP = 32'h05;
  localparam int unsigned IDX_CTL_PRI = 32'h06;
  localparam int unsigned IDX_CTL_SEC = 32'h07;
  localparam int unsigned IDX_GATE_CUR = 32'h08;
  localparam int unsigned IDX_OCP = 32'h09;
  localparam int unsigned IDX_STATUS = 32'h10;
  localparam logic [7:0] ADDR_FAULT_RESP = 8'(IDX_FAULT_RESP * 4);
  localparam logic [7:0] ADDR_CTL_PRI = 8'(IDX_CTL_PRI * 4);
  localparam logic [7:0] ADDR_CTL_SEC = 8'(IDX_CTL_SEC * 4);
  localparam logic [7:0] ADDR_GATE_CUR = 8'(IDX_GATE_CUR * 4);
  localparam logic [7:0] ADDR_OCP = 8'(IDX_OCP * 4);
  localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);

  // Reset values
  localparam logic [7:0] FAULT_RESP_RST = 8'h07;
  localparam logic [7:0] CTL_PRI_RST = 8'h35;
  localparam logic [7:0] CTL_SEC_RST = 8'h50;
  localparam logic [7:0] GATE_CUR_RST = 8'hFF;
  localparam logic [7:0] OCP_RST = 8'h00;

  // Field positions
  localparam int unsigned FR_SENSE_MODE_LSB = 6;
  localparam int unsigned FR_DRAIN_MODE_LSB = 4;
  localparam int unsigned FR_GATE_OFF_BIT = 3;
  localparam int unsigned FR_SENSE_OFF_LSB = 0;
  localparam int unsigned CP_CLEAR_BIT = 7;
  localparam int unsigned CP_LOCK_LSB = 4;
  localparam int unsigned CP_MODE_BIT = 3;
  localparam int unsigned CP_THRESH_LSB = 0;
  localparam int unsigned CS_DEAD_LSB = 6;
  localparam int unsigned CS_TRANS_LSB = 4;
  localparam int unsigned CS_BEMF_BIT = 3;
  localparam int unsigned CS_AMP_LSB = 0;
  localparam int unsigned GC_HIGH_LSB = 4;
  localparam int unsigned GC_LOW_LSB = 0;
  localparam int unsigned OC_DRAIN_TH_LSB = 4;
  localparam int unsigned OC_SENSE_RT_BIT = 3;
  localparam int unsigned OC_DRAIN_RT_BIT = 2;
  localparam int unsigned OC_FILTER_LSB = 0;
  // Status word layout
  localparam int unsigned ST_SUMMARY_BIT = 0;
  localparam int unsigned ST_SENSE_LSB = 1;
  localparam int unsigned ST_DRAIN_HI_LSB = 4;
  localparam int unsigned ST_DRAIN_LO_LSB = 7;
  localparam int unsigned ST_GATE_LSB = 10;
  localparam int unsigned ST_SENSE_PROT_BIT = 16;
  localparam int unsigned ST_DRAIN_PROT_BIT = 17;

  // Overcurrent response modes, lock codes and bus response codes
  localparam logic [1:0] MODE_LATCH = 2'h0;
  localparam logic [1:0] MODE_RETRY = 2'h1;
  localparam logic [1:0] MODE_REPORT = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  localparam logic [2:0] LOCK_ON = 3'h6;
  localparam logic [2:0] LOCK_OFF = 3'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing at mclk = 10 MHz; least times round up
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned DEG0_NS = 1570;
  localparam int unsigned DEG1_NS = 2380;
  localparam int unsigned DEG2_NS = 3490;
  localparam int unsigned DEG3_NS = 5730;
  localparam int unsigned RETRY_LONG_US = 4000;
  localparam int unsigned RETRY_SHORT_US = 70;
  localparam int unsigned EN_LOW_US = 850;
  localparam logic [5:0] DEG0_CYC =
    6'((DEG0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] DEG1_CYC =
    6'((DEG1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] DEG2_CYC =
    6'((DEG2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] DEG3_CYC =
    6'((DEG3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned RETRY_LONG_CYC =
    (RETRY_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] RETRY_SHORT_CYC =
    16'((RETRY_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned EN_LOW_CYC =
    (EN_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // AXI4-Lite request side, driven by the master
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  // AXI4-Lite answer side, driven by this slave
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

endpackage : fault_cfg_pkg

// >>> fault_cfg_regs.sv
// Fault response and configuration bank with overcurrent supervision
module fault_cfg_regs #(
  parameter logic [15:0] RETRY_LONG_CYC = 16'(fault_cfg_pkg::RETRY_LONG_CYC),
  parameter logic [15:0] EN_LOW_CYC = 16'(fault_cfg_pkg::EN_LOW_CYC)
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire fault_cfg_pkg::axil_req_t axil_req,
  output fault_cfg_pkg::axil_rsp_t axil_rsp,
  input wire logic [2:0] sense_oc_in,
  input wire logic [2:0] drain_hi_oc_in,
  input wire logic [2:0] drain_lo_oc_in,
  input wire logic [5:0] gate_src_fault_in,
  input wire logic enable_in,
  output logic fault_out_n,
  output logic sense_protect,
  output logic drain_protect,
  output logic input_mode_sel,
  output logic [2:0] sense_oc_thresh,
  output logic [1:0] deadband_sel,
  output logic [1:0] gate_transition_sel,
  output logic backemf_amp_on,
  output logic [2:0] diff_amp_on,
  output logic [3:0] high_drive_current,
  output logic [3:0] low_drive_current,
  output logic [3:0] drain_oc_thresh,
  output logic [1:0] oc_filter_sel
);

  // Whole state of the block in one record
  typedef struct packed {
    fault_cfg_pkg::axil_rsp_t rsp; // Bus answer flops
    logic aw_ok; // Write address held
    logic [7:0] aw_addr;
    logic w_ok; // Write data held
    logic [7:0] w_data; // Only lane 0 carries register bits
    logic w_lane0;
    logic [7:0] fault_resp; // Response modes and detector off bits
    logic [2:0] lock; // Write lock field
    logic mode; // Input mode
    logic [2:0] thresh; // Sense threshold code
    logic [7:0] ctl_sec;
    logic [7:0] gate_cur;
    logic [7:0] ocp;
    logic [15:0] sync1; // First synchroniser stage, read only by sync2
    logic [15:0] sync2;
    logic [5:0] s_deg; // Sense deglitch counter
    logic [5:0] d_deg; // Drain deglitch counter
    logic [15:0] s_rt; // Sense retry timer
    logic [15:0] d_rt; // Drain retry timer
    logic [15:0] en_cnt; // Enable-low duration
    logic [2:0] sense_oc_flag;
    logic [2:0] high_switch_drain_oc_flag;
    logic [2:0] low_switch_drain_oc_flag;
    logic [5:0] gate_flag;
    logic s_prot;
    logic d_prot;
    logic fault_n;
  } state_t;

  state_t q;
  state_t d;

  // Decoded views of the synchronised pins
  logic en_s;
  logic [2:0] sense_s;
  logic [2:0] dlo_s;
  logic [2:0] dhi_s;
  logic [5:0] gate_s;
  // Working terms
  logic [1:0] s_mode;
  logic [1:0] d_mode;
  logic locked;
  logic wr_go;
  logic wr_hit;
  logic clr_wr;
  logic en_evt;
  logic clr;
  logic [2:0] s_act;
  logic s_cond;
  logic d_cond;
  logic s_evt;
  logic d_evt;
  logic [5:0] deg_tgt;
  logic [5:0] g_new;
  logic [31:0] rd;
  logic rd_hit;

  // Next-state logic: bus, registers, detectors, flags
  always_comb
  begin
    d = q;
    // Two-stage synchroniser for every pin
    d.sync1 = {gate_src_fault_in, drain_hi_oc_in, drain_lo_oc_in,
               sense_oc_in, enable_in};
    d.sync2 = q.sync1;
    {gate_s, dhi_s, dlo_s, sense_s, en_s} = q.sync2;
    s_mode = q.fault_resp[fault_cfg_pkg::FR_SENSE_MODE_LSB +: 2];
    d_mode = q.fault_resp[fault_cfg_pkg::FR_DRAIN_MODE_LSB +: 2];
    locked = (q.lock == fault_cfg_pkg::LOCK_ON);

    // Address and data are taken independently, in either order
    if (axil_req.awvalid && q.rsp.awready)
    begin
      d.aw_ok = 1'b1;
      d.aw_addr = axil_req.awaddr;
      d.rsp.awready = 1'b0;
    end
    if (axil_req.wvalid && q.rsp.wready)
    begin
      d.w_ok = 1'b1;
      d.w_data = axil_req.wdata[7:0];
      d.w_lane0 = axil_req.wstrb[0];
      d.rsp.wready = 1'b0;
    end

    // Perform the write once both halves are held
    wr_go = q.aw_ok && q.w_ok && !q.rsp.bvalid;
    wr_hit = 1'b0;
    clr_wr = 1'b0;
    if (wr_go)
    begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.rsp.bvalid = 1'b1;
      case (q.aw_addr)
        fault_cfg_pkg::ADDR_FAULT_RESP:
        begin
          wr_hit = 1'b1;
          if (q.w_lane0 && !locked)
            d.fault_resp = q.w_data;
        end
        fault_cfg_pkg::ADDR_CTL_PRI:
        begin
          wr_hit = 1'b1;
          if (q.w_lane0)
          begin
            // Lock field stays writable; only the two codes act
            if (q.w_data[fault_cfg_pkg::CP_LOCK_LSB +: 3] ==
                fault_cfg_pkg::LOCK_ON ||
                q.w_data[fault_cfg_pkg::CP_LOCK_LSB +: 3] ==
                fault_cfg_pkg::LOCK_OFF)
              d.lock = q.w_data[fault_cfg_pkg::CP_LOCK_LSB +: 3];
            if (!locked)
            begin
              d.mode = q.w_data[fault_cfg_pkg::CP_MODE_BIT];
              d.thresh = q.w_data[fault_cfg_pkg::CP_THRESH_LSB +: 3];
              clr_wr = q.w_data[fault_cfg_pkg::CP_CLEAR_BIT];
            end
          end
        end
        fault_cfg_pkg::ADDR_CTL_SEC:
        begin
          wr_hit = 1'b1;
          if (q.w_lane0 && !locked)
            d.ctl_sec = q.w_data;
        end
        fault_cfg_pkg::ADDR_GATE_CUR:
        begin
          wr_hit = 1'b1;
          if (q.w_lane0 && !locked)
            d.gate_cur = q.w_data;
        end
        fault_cfg_pkg::ADDR_OCP:
        begin
          wr_hit = 1'b1;
          if (q.w_lane0 && !locked)
            d.ocp = q.w_data;
        end
        fault_cfg_pkg::ADDR_STATUS:
          wr_hit = 1'b1; // Read-only, write ignored
        default:
          wr_hit = 1'b0;
      endcase
      d.rsp.bresp = wr_hit ? fault_cfg_pkg::RESP_OKAY
                           : fault_cfg_pkg::RESP_SLVERR;
    end
    // Response accepted: ready for the next write
    if (q.rsp.bvalid && axil_req.bready)
    begin
      d.rsp.bvalid = 1'b0;
      d.rsp.awready = 1'b1;
      d.rsp.wready = 1'b1;
    end

    // Read data, sampled at the address handshake
    rd = '0;
    rd_hit = 1'b1;
    case (axil_req.araddr)
      fault_cfg_pkg::ADDR_FAULT_RESP:
        rd[7:0] = q.fault_resp;
      fault_cfg_pkg::ADDR_CTL_PRI:
      begin
        // Clear bit always reads zero
        rd[fault_cfg_pkg::CP_LOCK_LSB +: 3] = q.lock;
        rd[fault_cfg_pkg::CP_MODE_BIT] = q.mode;
        rd[fault_cfg_pkg::CP_THRESH_LSB +: 3] = q.thresh;
      end
      fault_cfg_pkg::ADDR_CTL_SEC:
        rd[7:0] = q.ctl_sec;
      fault_cfg_pkg::ADDR_GATE_CUR:
        rd[7:0] = q.gate_cur;
      fault_cfg_pkg::ADDR_OCP:
        rd[7:0] = q.ocp;
      fault_cfg_pkg::ADDR_STATUS:
      begin
        rd[fault_cfg_pkg::ST_SUMMARY_BIT] = !q.fault_n;
        rd[fault_cfg_pkg::ST_SENSE_LSB +: 3] = q.sense_oc_flag;
        rd[fault_cfg_pkg::ST_DRAIN_HI_LSB +: 3] = q.high_switch_drain_oc_flag;
        rd[fault_cfg_pkg::ST_DRAIN_LO_LSB +: 3] = q.low_switch_drain_oc_flag;
        rd[fault_cfg_pkg::ST_GATE_LSB +: 6] = q.gate_flag;
        rd[fault_cfg_pkg::ST_SENSE_PROT_BIT] = q.s_prot;
        rd[fault_cfg_pkg::ST_DRAIN_PROT_BIT] = q.d_prot;
      end
      default:
        rd_hit = 1'b0;
    endcase
    if (axil_req.arvalid && q.rsp.arready)
    begin
      d.rsp.arready = 1'b0;
      d.rsp.rvalid = 1'b1;
      d.rsp.rdata = rd;
      d.rsp.rresp = rd_hit ? fault_cfg_pkg::RESP_OKAY
                           : fault_cfg_pkg::RESP_SLVERR;
    end
    if (q.rsp.rvalid && axil_req.rready)
    begin
      d.rsp.rvalid = 1'b0;
      d.rsp.arready = 1'b1;
    end

    // Enable low for longer than the sleep time acts as a clear
    en_evt = !en_s && (q.en_cnt == EN_LOW_CYC);
    if (en_s)
      d.en_cnt = '0;
    else if (q.en_cnt <= EN_LOW_CYC)
      d.en_cnt = q.en_cnt + 16'h0001;
    clr = clr_wr || en_evt;

    // Shared deglitch time for both detectors
    case (q.ocp[fault_cfg_pkg::OC_FILTER_LSB +: 2])
      2'h0: deg_tgt = fault_cfg_pkg::DEG0_CYC;
      2'h1: deg_tgt = fault_cfg_pkg::DEG1_CYC;
      2'h2: deg_tgt = fault_cfg_pkg::DEG2_CYC;
      default: deg_tgt = fault_cfg_pkg::DEG3_CYC;
    endcase

    // Detector conditions; disabled channels and mode 11 never count
    s_act = sense_s &
            ~q.fault_resp[fault_cfg_pkg::FR_SENSE_OFF_LSB +: 3];
    s_cond = (|s_act) && (s_mode != fault_cfg_pkg::MODE_OFF);
    d_cond = (|{dhi_s, dlo_s}) && (d_mode != fault_cfg_pkg::MODE_OFF);
    // Counter saturates, so one unbroken excursion gives one event
    s_evt = s_cond && (q.s_deg == deg_tgt - 6'h01);
    d_evt = d_cond && (q.d_deg == deg_tgt - 6'h01);
    if (!s_cond)
      d.s_deg = '0;
    else if (q.s_deg < deg_tgt)
      d.s_deg = q.s_deg + 6'h01;
    if (!d_cond)
      d.d_deg = '0;
    else if (q.d_deg < deg_tgt)
      d.d_deg = q.d_deg + 6'h01;
    g_new = gate_s & {6{!q.fault_resp[fault_cfg_pkg::FR_GATE_OFF_BIT]}};

    // Flags: clear first, then new events, so a set wins
    if (clr)
    begin
      d.sense_oc_flag = '0;
      d.high_switch_drain_oc_flag = '0;
      d.low_switch_drain_oc_flag = '0;
      d.gate_flag = '0;
      d.s_prot = 1'b0;
      d.d_prot = 1'b0;
      d.s_rt = '0;
      d.d_rt = '0;
    end
    d.gate_flag = d.gate_flag | g_new;

    // Retry timers release protection when they run out
    if (d.s_rt != '0)
    begin
      if (d.s_rt == 16'h0001)
        d.s_prot = 1'b0;
      d.s_rt = d.s_rt - 16'h0001;
    end
    if (d.d_rt != '0)
    begin
      if (d.d_rt == 16'h0001)
        d.d_prot = 1'b0;
      d.d_rt = d.d_rt - 16'h0001;
    end

    // Sense event: every live mode reports, only 00 and 01 act
    if (s_evt)
    begin
      d.sense_oc_flag = d.sense_oc_flag | s_act;
      if (s_mode == fault_cfg_pkg::MODE_LATCH)
      begin
        d.s_prot = 1'b1;
        d.s_rt = '0;
      end
      else if (s_mode == fault_cfg_pkg::MODE_RETRY)
      begin
        d.s_prot = 1'b1;
        d.s_rt = q.ocp[fault_cfg_pkg::OC_SENSE_RT_BIT] ?
                 fault_cfg_pkg::RETRY_SHORT_CYC : RETRY_LONG_CYC;
      end
    end
    // Drain event: per-switch flags, same response scheme
    if (d_evt)
    begin
      d.high_switch_drain_oc_flag = d.high_switch_drain_oc_flag | dhi_s;
      d.low_switch_drain_oc_flag = d.low_switch_drain_oc_flag | dlo_s;
      if (d_mode == fault_cfg_pkg::MODE_LATCH)
      begin
        d.d_prot = 1'b1;
        d.d_rt = '0;
      end
      else if (d_mode == fault_cfg_pkg::MODE_RETRY)
      begin
        d.d_prot = 1'b1;
        d.d_rt = q.ocp[fault_cfg_pkg::OC_DRAIN_RT_BIT] ?
                 fault_cfg_pkg::RETRY_SHORT_CYC : RETRY_LONG_CYC;
      end
    end
    // Fault pin low while any flag stands
    d.fault_n = !(|{d.sense_oc_flag, d.high_switch_drain_oc_flag,
                    d.low_switch_drain_oc_flag, d.gate_flag});
  end

  // State register, synchronous active-low reset
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.rsp.awready <= 1'b1;
      q.rsp.wready <= 1'b1;
      q.rsp.arready <= 1'b1;
      q.fault_resp <= fault_cfg_pkg::FAULT_RESP_RST;
      q.lock <=
        fault_cfg_pkg::CTL_PRI_RST[fault_cfg_pkg::CP_LOCK_LSB +: 3];
      q.mode <= fault_cfg_pkg::CTL_PRI_RST[fault_cfg_pkg::CP_MODE_BIT];
      q.thresh <=
        fault_cfg_pkg::CTL_PRI_RST[fault_cfg_pkg::CP_THRESH_LSB +: 3];
      q.ctl_sec <= fault_cfg_pkg::CTL_SEC_RST;
      q.gate_cur <= fault_cfg_pkg::GATE_CUR_RST;
      q.ocp <= fault_cfg_pkg::OCP_RST;
      q.fault_n <= 1'b1;
      q.sync1 <= 16'hFFFF & 16'h0001; // Enable assumed high
      q.sync2 <= 16'h0001;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign axil_rsp = q.rsp;
  assign fault_out_n = q.fault_n;
  assign sense_protect = q.s_prot;
  assign drain_protect = q.d_prot;
  assign input_mode_sel = q.mode;
  assign sense_oc_thresh = q.thresh;
  assign deadband_sel = q.ctl_sec[fault_cfg_pkg::CS_DEAD_LSB +: 2];
  assign gate_transition_sel =
    q.ctl_sec[fault_cfg_pkg::CS_TRANS_LSB +: 2];
  assign backemf_amp_on = q.ctl_sec[fault_cfg_pkg::CS_BEMF_BIT];
  assign diff_amp_on = q.ctl_sec[fault_cfg_pkg::CS_AMP_LSB +: 3];
  assign high_drive_current =
    q.gate_cur[fault_cfg_pkg::GC_HIGH_LSB +: 4];
  assign low_drive_current =
    q.gate_cur[fault_cfg_pkg::GC_LOW_LSB +: 4];
  assign drain_oc_thresh = q.ocp[fault_cfg_pkg::OC_DRAIN_TH_LSB +: 4];
  assign oc_filter_sel = q.ocp[fault_cfg_pkg::OC_FILTER_LSB +: 2];

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Latched sense protection holds until a clear
  AST_SENSE_LATCH: assert property (
    (q.s_prot && q.s_rt == '0 && !clr) |=> q.s_prot)
    else $error("sense latch released without clear");

  // Report-only sense event lowers the pin, no protection
  AST_SENSE_REPORT: assert property (
    (s_evt && s_mode == fault_cfg_pkg::MODE_REPORT && !q.s_prot)
    |=> (!q.fault_n && !q.s_prot))
    else $error("sense report mode misbehaved");

  // Disabled sense mode raises no new flag
  AST_SENSE_OFF: assert property (
    (s_mode == fault_cfg_pkg::MODE_OFF)
    |=> ((q.sense_oc_flag & ~$past(q.sense_oc_flag)) == 3'h0))
    else $error("sense flag set while disabled");

  // Drain latch mode protects after the event
  AST_DRAIN_LATCH: assert property (
    (d_evt && d_mode == fault_cfg_pkg::MODE_LATCH) |=> q.d_prot)
    else $error("drain latch not applied");

  // Disabled drain mode never gives an event
  AST_DRAIN_OFF: assert property (
    (d_mode == fault_cfg_pkg::MODE_OFF) |-> !d_evt)
    else $error("drain event while disabled");

  // Clear with no new event empties flags and protection
  AST_CLEAR: assert property (
    (clr && !s_evt && !d_evt && g_new == 6'h00)
    |=> (q.fault_n && !q.s_prot && !q.d_prot))
    else $error("clear left a fault standing");

  // Gate fault disable stops new gate flags
  AST_GATE_OFF: assert property (
    q.fault_resp[fault_cfg_pkg::FR_GATE_OFF_BIT]
    |=> ((q.gate_flag & ~$past(q.gate_flag)) == 6'h00))
    else $error("gate flag set while disabled");

  // Locked writes leave the bank unchanged apart from the lock
  AST_LOCKED: assert property (
    (wr_go && locked)
    |=> ($stable(q.fault_resp) && $stable(q.ctl_sec) &&
         $stable(q.ocp) && $stable(q.gate_cur) && $stable(q.mode)))
    else $error("register changed while locked");

  // Lock field only ever holds one of the two codes
  AST_LOCK_CODES: assert property (
    (q.lock == fault_cfg_pkg::LOCK_ON) || (q.lock == fault_cfg_pkg::LOCK_OFF))
    else $error("lock field holds a stray value");

  // Retry ends exactly when the timer runs out
  AST_RETRY_END: assert property (
    (q.s_rt == 16'h0001 && !s_evt && !clr) |=> (!q.s_prot && q.s_rt == '0))
    else $error("sense retry did not release");

  // An event only after the full deglitch run
  AST_DEGLITCH: assert property (
    s_evt |-> (s_cond && $past(s_cond) && q.s_deg == deg_tgt - 6'h01))
    else $error("sense event before deglitch time");

endmodule : fault_cfg_regs

// >>> host_model.sv
// Host side of the register bus; bench calls wr and rd
module host_model (
  input wire logic mclk,
  output fault_cfg_pkg::axil_req_t req,
  input wire fault_cfg_pkg::axil_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus idle from time zero
  initial req = '0;

  // One write; each channel drops once taken, then wait for the answer
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge mclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge mclk);
      aw_done = aw_done | (req.awvalid & rsp.awready);
      w_done = w_done | (req.wvalid & rsp.wready);
      if (aw_done)
        req.awvalid <= 1'b0;
      if (w_done)
        req.wvalid <= 1'b0;
    end
    do @(posedge mclk); while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  // One read; rready held until the data shows
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge mclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge mclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge mclk); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
endmodule : host_model

// >>> motor_driver_fault_config_regs_tb.sv
module motor_driver_fault_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, e) \
  begin \
    checks++; \
    if ((a) !== (e)) \
    begin \
      bad_count++; \
      $display("unexpected at %0t: got %0h want %0h", $time, a, e); \
    end \
  end
  localparam logic [7:0] A_FR = fault_cfg_pkg::ADDR_FAULT_RESP;
  localparam logic [7:0] A_CP = fault_cfg_pkg::ADDR_CTL_PRI;
  localparam logic [7:0] A_CS = fault_cfg_pkg::ADDR_CTL_SEC;
  localparam logic [7:0] A_GC = fault_cfg_pkg::ADDR_GATE_CUR;
  localparam logic [7:0] A_OC = fault_cfg_pkg::ADDR_OCP;
  localparam logic [1:0] OK = fault_cfg_pkg::RESP_OKAY;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  fault_cfg_pkg::axil_req_t req;
  fault_cfg_pkg::axil_rsp_t rsp;
  logic [2:0] sense = 3'h0;
  logic [2:0] dhi = 3'h0;
  logic [2:0] dlo = 3'h0;
  logic [5:0] gsf = 6'h00;
  logic en_pin = 1'b1;
  logic fault_n, s_prot, d_prot, mode, bemf;
  logic [2:0] thr, amps;
  logic [1:0] dead, trans, filt, resp;
  logic [3:0] hi_cur, lo_cur, d_thr;
  logic [31:0] rdat;
  int checks = 0;
  int bad_count = 0;

  // 10 MHz clock
  always #50 mclk = ~mclk;

  // Long counts shortened so retry and enable waits stay brief
  fault_cfg_regs #(.RETRY_LONG_CYC(16'h0032), .EN_LOW_CYC(16'h0014))
  fault_cfg_regs_inst (.mclk(mclk), .resetn(resetn), .axil_req(req),
    .axil_rsp(rsp), .sense_oc_in(sense), .drain_hi_oc_in(dhi),
    .drain_lo_oc_in(dlo), .gate_src_fault_in(gsf), .enable_in(en_pin),
    .fault_out_n(fault_n), .sense_protect(s_prot), .drain_protect(d_prot),
    .input_mode_sel(mode), .sense_oc_thresh(thr), .deadband_sel(dead),
    .gate_transition_sel(trans), .backemf_amp_on(bemf), .diff_amp_on(amps),
    .high_drive_current(hi_cur), .low_drive_current(lo_cur),
    .drain_oc_thresh(d_thr), .oc_filter_sel(filt));
  host_model host_model_inst (.mclk(mclk), .req(req), .rsp(rsp));

  task automatic wchk(input logic [7:0] a, input logic [7:0] d);
    host_model_inst.wr(a, d, resp);
    `CHK(resp, OK)
  endtask : wchk
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] r);
    host_model_inst.rd(a, rdat, resp);
    `CHK(rdat, e)
    `CHK(resp, r)
  endtask : rchk
  // Raise one comparator for n cycles: 0 sense bit 2, 1 drain high,
  // 3 drain low, others gate
  task automatic pulse(input int which, input int n);
    @(posedge mclk);
    case (which)
      0: sense[2] <= 1'b1;
      1: dhi[0] <= 1'b1;
      3: dlo[1] <= 1'b1;
      default: gsf[0] <= 1'b1;
    endcase
    repeat (n) @(posedge mclk);
    sense <= 3'h0;
    dhi <= 3'h0;
    dlo <= 3'h0;
    gsf <= 6'h00;
    repeat (4) @(posedge mclk);
  endtask : pulse

  task automatic t_reset;
    rchk(A_FR, 32'h07, OK);
    rchk(A_CP, 32'h35, OK);
    rchk(A_CS, 32'h50, OK);
    rchk(A_GC, 32'hFF, OK);
    rchk(A_OC, 32'h00, OK);
    rchk(8'h00, 32'h0, fault_cfg_pkg::RESP_SLVERR);
    `CHK({thr, trans}, 5'h15)
  endtask : t_reset
  task automatic t_fields;
    wchk(A_CS, 8'hAF);
    `CHK({dead, trans, bemf, amps}, 8'hAF)
    wchk(A_GC, 8'h3C);
    `CHK({hi_cur, lo_cur}, 8'h3C)
    wchk(A_OC, 8'h90);
    `CHK({d_thr, filt}, 6'h24)
    wchk(A_CP, 8'h3F);
    `CHK({mode, thr}, 4'hF)
    wchk(A_CP, 8'h35);
  endtask : t_fields
  task automatic t_sense;
    wchk(A_FR, 8'h03);
    pulse(0, 10);
    `CHK(fault_n, 1'b1)
    pulse(0, 30);
    repeat (20) @(posedge mclk);
    `CHK({fault_n, s_prot}, 2'h1)
    wchk(A_CP, 8'hB5);
    `CHK({fault_n, s_prot}, 2'h2)
    rchk(A_CP, 32'h35, OK);
    wchk(A_FR, 8'h43);
    pulse(0, 30);
    `CHK(s_prot, 1'b1)
    repeat (50) @(posedge mclk);
    `CHK({fault_n, s_prot}, 2'h0)
    wchk(A_CP, 8'hB5);
    wchk(A_FR, 8'h83);
    pulse(0, 30);
    `CHK({fault_n, s_prot}, 2'h0)
    rchk(fault_cfg_pkg::ADDR_STATUS, 32'h9, OK);
    wchk(A_CP, 8'hB5);
    wchk(A_FR, 8'hC3);
    pulse(0, 30);
    `CHK({fault_n, s_prot}, 2'h2)
  endtask : t_sense
  task automatic t_drain;
    wchk(A_FR, 8'h17);
    pulse(1, 30);
    `CHK(d_prot, 1'b1)
    repeat (50) @(posedge mclk);
    `CHK(d_prot, 1'b0)
    wchk(A_CP, 8'hB5);
    wchk(A_FR, 8'h07);
    pulse(1, 30);
    `CHK(d_prot, 1'b1)
    en_pin <= 1'b0;
    repeat (30) @(posedge mclk);
    en_pin <= 1'b1;
    `CHK({fault_n, d_prot}, 2'h2)
    wchk(A_FR, 8'h27);
    pulse(1, 30);
    `CHK({fault_n, d_prot}, 2'h0)
    pulse(3, 30);
    rchk(fault_cfg_pkg::ADDR_STATUS, 32'h111, OK);
    wchk(A_CP, 8'hB5);
    wchk(A_FR, 8'h37);
    pulse(1, 30);
    `CHK(fault_n, 1'b1)
  endtask : t_drain
  task automatic t_gate;
    wchk(A_FR, 8'h07);
    pulse(2, 5);
    `CHK(fault_n, 1'b0)
    wchk(A_CP, 8'hB5);
    wchk(A_FR, 8'h0F);
    pulse(2, 5);
    `CHK(fault_n, 1'b1)
  endtask : t_gate
  task automatic t_lock;
    wchk(A_CP, 8'h65);
    wchk(A_CS, 8'h00);
    rchk(A_CS, 32'hAF, OK);
    wchk(A_CP, 8'h25);
    wchk(A_CS, 8'h00);
    rchk(A_CP, 32'h65, OK);
    `CHK(dead, 2'h2)
    wchk(A_CP, 8'h35);
    wchk(A_CS, 8'h00);
    rchk(A_CS, 32'h00, OK);
  endtask : t_lock

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // Watchdog: the whole sequence needs under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    close_out();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    $display("reset test done");
    t_fields();
    $display("field test done");
    t_sense();
    $display("sense test done");
    t_drain();
    $display("drain test done");
    t_gate();
    $display("gate test done");
    t_lock();
    $display("lock test done");
    close_out();
  end
endmodule : motor_driver_fault_config_regs_tb
